// >>> rtl/sau_core.sv
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps

// Summary of operation
// - Signed clamp gives low bound below, high bound above, else value.
// - Unsigned clamp gives zero if negative, 2^n-1 above, else value.
// - Clamp differing from unclamped value sets the sticky flag.
// - Arithmetic never clears the sticky flag; only a status write does.
// - Current sticky flag value is readable through the status read.
// - Signed word clamp accepts width one to thirty-two.
// - Unsigned word clamp accepts width zero to thirty-one.
// - Word clamps may shift first: right arithmetic 1-31 or left 0-31.
// - Signed word clamp shifts, then clamps to signed width.
// - Unsigned word clamp treats source signed, shifts, clamps unsigned.
// - No saturating operation changes the N, Z, C or V flags.
// - Signed dual-half clamp accepts width one to sixteen.
// - Unsigned dual-half clamp accepts width zero to fifteen.
// - Signed dual-half clamp limits each half independently in place.
// - Unsigned dual-half clamp limits each half independently in place.
// - Word add and subtract clamp to the signed 32-bit range.
// - Byte add and subtract clamp four signed 8-bit lanes.
// - Half add and subtract clamp two signed 16-bit lanes.
// - Byte and half lane add and subtract never touch the flag.
// - Subtraction takes second operand lanes from first operand lanes.
// - Omitted destination writes the result to the first operand reg.
module sau_core
   import sau_pkg::*;
#(
   parameter int CNT_W = 16
)(
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic                  instValid,
   input  wire logic [3:0]            instOp,
   input  wire logic                  instCondPass,
   input  wire logic [5:0]            instWidth,
   input  wire logic                  instShiftRight,
   input  wire logic [4:0]            instShiftAmt,
   input  wire logic [SAU_REG_W-1:0]  instDest,
   input  wire logic                  instDestOmitted,
   input  wire logic [SAU_REG_W-1:0]  instFirstReg,
   input  wire logic [SAU_XLEN-1:0]   opFirst,
   input  wire logic [SAU_XLEN-1:0]   opSecond,
   output logic                       resValid,
   output logic [SAU_XLEN-1:0]        resData,
   output logic [SAU_REG_W-1:0]       resReg,
   output logic                       instRejected,
   output logic                       stickySat,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic [31:0]                hrdata,
   output logic                       hresp
);

   // Counter must fit one bus word
   if (CNT_W < 1 || CNT_W > SAU_XLEN) begin : gCheck
      $error("sau_core: CNT_W must lie between 1 and 32");
   end

   // The datapath word is the bus word
   if (SAU_XLEN != $bits(hrdata)) begin : gWordCheck
      $error("sau_core: datapath and bus word widths differ");
   end

   // Two halfword lanes must fill one word
   if (SAU_HALF * 2 != SAU_XLEN) begin : gHalfCheck
      $error("sau_core: two halfword lanes must fill one word");
   end

   // Byte lanes must tile the word with nothing left over
   if (SAU_XLEN % SAU_BYTE != 0) begin : gByteCheck
      $error("sau_core: byte lanes must tile the word exactly");
   end

   // Result register index needs at least one bit
   if (SAU_REG_W < 1) begin : gRegCheck
      $error("sau_core: register index width must be positive");
   end

   // Most lanes the lane arithmetic visits: the byte lanes
   localparam int LANES_MAX = SAU_XLEN / SAU_BYTE;

   // Whole state of the block
   typedef struct packed {
      logic                  resValid;
      logic [SAU_XLEN-1:0]   resData;
      logic [SAU_REG_W-1:0]  resReg;
      logic                  rejected;
      logic                  qFlag;
      logic [CNT_W-1:0]      satCnt;
      logic                  wrPend;
      logic [SAU_ADDR_W-1:0] wrAddr;
      logic [31:0]           rdData;
   } sau_state_s;

   sau_state_s st_r;
   sau_state_s st_nxt;

   // Sign extend the low w bits of a word to 64 bits
   // Shifting up and back down copies the lane's top bit upward
   function automatic logic signed [63:0] sext(
      input logic [SAU_XLEN-1:0] v,
      input logic [6:0]          w
   );
      logic [63:0] t;
      logic [6:0]  sh;
      sh = 7'h40 - w;
      t  = {32'h0, v} << sh;
      return $signed(t) >>> sh;
   endfunction

   // Signed clamp to n bits; top bit of result marks saturation
   function automatic logic [SAU_XLEN:0] sclamp(
      input logic signed [63:0] v,
      input logic [5:0]         n
   );
      logic signed [63:0] hi;
      logic signed [63:0] lo;
      hi = (64'sh1 <<< (n - 6'h01)) - 64'sh1;
      // Low bound is one below the negated high bound
      lo = -hi - 64'sh1;
      if (v < lo) begin
         return {1'b1, lo[SAU_XLEN-1:0]};
      end else if (v > hi) begin
         return {1'b1, hi[SAU_XLEN-1:0]};
      end else begin
         return {1'b0, v[SAU_XLEN-1:0]};
      end
   endfunction

   // Unsigned clamp to n bits; top bit of result marks saturation
   function automatic logic [SAU_XLEN:0] uclamp(
      input logic signed [63:0] v,
      input logic [5:0]         n
   );
      logic signed [63:0] hi;
      // A width of zero leaves a ceiling of zero
      hi = (64'sh1 <<< n) - 64'sh1;
      if (v < 64'sh0) begin
         return {1'b1, 32'h0};
      end else if (v > hi) begin
         return {1'b1, hi[SAU_XLEN-1:0]};
      end else begin
         return {1'b0, v[SAU_XLEN-1:0]};
      end
   endfunction

   // Lane mask of the low w bits
   function automatic logic [SAU_XLEN-1:0] laneMask(input logic [6:0] w);
      return 32'hffffffff >> (7'h20 - w);
   endfunction

   // Per-lane signed add or subtract with clamp to the lane width
   function automatic logic [SAU_XLEN:0] laneArith(
      input logic [SAU_XLEN-1:0] a,
      input logic [SAU_XLEN-1:0] b,
      input logic                sub,
      input logic [6:0]          w
   );
      logic [SAU_XLEN-1:0] res;
      logic                sat;
      logic signed [63:0]  x;
      logic signed [63:0]  y;
      logic [SAU_XLEN:0]   c;
      logic [6:0]          pos;
      res = 32'h0;
      sat = 1'b0;
      // Lanes that start past the word end are skipped
      for (int i = 0; i < LANES_MAX; i++) begin
         pos = 7'(i) * w;
         if (pos < 7'h20) begin
            x = sext(a >> pos, w);
            y = sext(b >> pos, w);
            // second operand lane taken from the first
            c = sclamp(sub ? x - y : x + y, w[5:0]);
            res = res | ((c[SAU_XLEN-1:0] & laneMask(w)) << pos);
            sat = sat | c[SAU_XLEN];
         end
      end
      return {sat, res};
   endfunction

   // Clamp both halfwords independently, signed or unsigned range
   function automatic logic [SAU_XLEN:0] halfClamp(
      input logic [SAU_XLEN-1:0] src,
      input logic [5:0]          n,
      input logic                isSigned
   );
      logic [SAU_XLEN:0] lo;
      logic [SAU_XLEN:0] hi;
      lo = isSigned ? sclamp(sext(src, 7'h10), n)
                    : uclamp(sext(src, 7'h10), n);
      hi = isSigned ? sclamp(sext(src >> SAU_HALF, 7'h10), n)
                    : uclamp(sext(src >> SAU_HALF, 7'h10), n);
      // Saturation of either half counts for the word
      return {lo[SAU_XLEN] | hi[SAU_XLEN],
              hi[SAU_HALF-1:0], lo[SAU_HALF-1:0]};
   endfunction

   // Optional pre-shift of a word clamp source
   function automatic logic signed [63:0] preShift(
      input logic [SAU_XLEN-1:0] src,
      input logic                right,
      input logic [4:0]          amt
   );
      logic [SAU_XLEN-1:0] s;
      // Bits pushed off the top by a left shift are lost
      s = right ? SAU_XLEN'($signed(src) >>> amt) : src << amt;
      return sext(s, 7'h20);
   endfunction

   // Execution and register access
   always_comb begin
      logic [SAU_XLEN:0] exec;
      logic              legal;
      logic              affectsQ;
      logic              fire;
      logic              satEvt;
      logic              addrHit;
      logic              shOk;
      exec     = '0;
      legal    = 1'b0;
      affectsQ = 1'b0;
      fire     = 1'b0;
      satEvt   = 1'b0;
      addrHit  = 1'b0;
      shOk     = !instShiftRight || instShiftAmt >= SAU_ASR_MIN;
      // Pulses drop each cycle; all other state holds
      st_nxt   = st_r;
      st_nxt.resValid = 1'b0;
      st_nxt.rejected = 1'b0;

      // Operation select and width checks
      case (instOp)
         SAU_OP_SWC: begin
            legal = shOk && instWidth >= SAU_SWC_MIN
                    && instWidth <= SAU_SWC_MAX;
            affectsQ = 1'b1;
            exec = sclamp(preShift(opSecond, instShiftRight,
                                   instShiftAmt), instWidth);
         end
         SAU_OP_UWC: begin
            legal = shOk && instWidth <= SAU_UWC_MAX;
            affectsQ = 1'b1;
            exec = uclamp(preShift(opSecond, instShiftRight,
                                   instShiftAmt), instWidth);
         end
         SAU_OP_SDHC: begin
            legal = instWidth >= SAU_SDHC_MIN && instWidth <= SAU_SDHC_MAX;
            affectsQ = 1'b1;
            exec = halfClamp(opSecond, instWidth, 1'b1);
         end
         SAU_OP_UDHC: begin
            legal = instWidth <= SAU_UDHC_MAX;
            affectsQ = 1'b1;
            exec = halfClamp(opSecond, instWidth, 1'b0);
         end
         SAU_OP_ADDW, SAU_OP_SUBW: begin
            legal = 1'b1;
            affectsQ = 1'b1;
            exec = laneArith(opFirst, opSecond, instOp[0], 7'h20);
         end
         SAU_OP_ADDB, SAU_OP_SUBB: begin
            legal = 1'b1;
            exec = laneArith(opFirst, opSecond, instOp[0], 7'(SAU_BYTE));
         end
         SAU_OP_ADDH, SAU_OP_SUBH: begin
            legal = 1'b1;
            exec = laneArith(opFirst, opSecond, instOp[0], 7'(SAU_HALF));
         end
         default: begin
            legal = 1'b0;
         end
      endcase

      fire = instValid && instCondPass && legal;
      // byte and half lane operations never raise the flag
      satEvt = fire && affectsQ && exec[SAU_XLEN];

      // Result write-back; flags N, Z, C, V have no path here
      // condition flags untouched
      if (fire) begin
         st_nxt.resValid = 1'b1;
         st_nxt.resData  = exec[SAU_XLEN-1:0];
         // omitted destination takes first operand reg
         st_nxt.resReg = instDestOmitted ? instFirstReg : instDest;
      end
      st_nxt.rejected = instValid && instCondPass && !legal;

      // Bus data phase of a write
      // hwdata is valid only now, one cycle after its address
      if (st_r.wrPend && st_r.wrAddr == SAU_ADDR_STATUS) begin
         // flag cleared only by status write
         st_nxt.qFlag = hwdata[SAU_STAT_Q_BIT];
      end
      // saturation sets the sticky flag, set wins
      if (satEvt) begin
         st_nxt.qFlag = 1'b1;
         // Counter sticks at all ones instead of wrapping
         if (st_r.satCnt != {CNT_W{1'b1}}) begin
            st_nxt.satCnt = st_r.satCnt + CNT_W'(1);
         end
      end

      // Bus address phase
      // hsize is not decoded: only whole words are served
      // Read data is latched now and stands through the data phase
      addrHit = hsel && htrans == SAU_HTRANS_NONSEQ && hready;
      st_nxt.wrPend = addrHit && hwrite;
      if (addrHit) begin
         st_nxt.wrAddr = haddr[SAU_ADDR_W-1:0];
      end
      if (addrHit && !hwrite) begin
         case (haddr[SAU_ADDR_W-1:0])
            SAU_ADDR_STATUS: begin
               st_nxt.rdData = 32'(st_r.qFlag) << SAU_STAT_Q_BIT;
            end
            SAU_ADDR_SATCNT: begin
               st_nxt.rdData = 32'(st_r.satCnt);
            end
            default: begin
               st_nxt.rdData = 32'h0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0; // All state clears to zero
      end else begin
         st_r <= st_nxt;
      end
   end

   // Instruction results, all straight from flip-flops
   assign resValid     = st_r.resValid;
   assign resData      = st_r.resData;
   assign resReg       = st_r.resReg;
   assign instRejected = st_r.rejected;
   assign stickySat    = st_r.qFlag;

   // Bus replies; the slave never stalls and never errors
   assign hrdata       = st_r.rdData;
   assign hreadyout    = 1'b1;            // Zero wait states
   assign hresp        = SAU_HRESP_OKAY;  // Always OKAY

endmodule // sau_core

// >>> rtl/sau_pkg.sv
// Shared constants for the saturating arithmetic unit
package sau_pkg;

   // Datapath widths
   localparam int SAU_XLEN  = 32;
   localparam int SAU_HALF  = 16;
   localparam int SAU_BYTE  = 8;
   localparam int SAU_REG_W = 4;

   // Accepted target width fields per operation
   localparam logic [5:0] SAU_SWC_MIN  = 6'h01;
   localparam logic [5:0] SAU_SWC_MAX  = 6'h20;
   localparam logic [5:0] SAU_UWC_MAX  = 6'h1f;
   localparam logic [5:0] SAU_SDHC_MIN = 6'h01;
   localparam logic [5:0] SAU_SDHC_MAX = 6'h10;
   localparam logic [5:0] SAU_UDHC_MAX = 6'h0f;

   // Least arithmetic right shift amount
   localparam logic [4:0] SAU_ASR_MIN = 5'h01;

   // Register map, byte addresses
   localparam int         SAU_ADDR_W      = 8;
   localparam logic [7:0] SAU_ADDR_STATUS = 8'h00;
   localparam logic [7:0] SAU_ADDR_SATCNT = 8'h04;
   localparam int         SAU_STAT_Q_BIT  = 0;

   // AHB-Lite encodings
   localparam logic [1:0] SAU_HTRANS_NONSEQ = 2'h2;
   localparam logic       SAU_HRESP_OKAY    = 1'h0;

   // Operation codes from the decoder
   typedef enum logic [3:0] {
      SAU_OP_SWC  = 4'b0000, // signed_word_clamp
      SAU_OP_UWC  = 4'b0001, // unsigned_word_clamp
      SAU_OP_SDHC = 4'b0010, // signed_dual_half_clamp
      SAU_OP_UDHC = 4'b0011, // unsigned_dual_half_clamp
      SAU_OP_ADDW = 4'b0100, // sat_add_word
      SAU_OP_SUBW = 4'b0101, // sat_sub_word
      SAU_OP_ADDB = 4'b0110, // sat_add_bytes
      SAU_OP_SUBB = 4'b0111, // sat_sub_bytes
      SAU_OP_ADDH = 4'b1000, // sat_add_halves
      SAU_OP_SUBH = 4'b1001  // sat_sub_halves
   } sau_op_e;

endpackage

// >>> verification/sau_checker.sv
`timescale 1ns/100ps
// Port-level checks of the saturating unit
module sau_checker
   import sau_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        instValid,
   input wire logic [3:0]  instOp,
   input wire logic        instCondPass,
   input wire logic [31:0] opFirst,
   input wire logic [31:0] opSecond,
   input wire logic        resValid,
   input wire logic [31:0] resData,
   input wire logic        instRejected,
   input wire logic        stickySat,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp
);
   logic        wrPend;
   logic [32:0] addX;
   logic [31:0] addSat;
   // Status write sitting in its data phase
   always_ff @(posedge clk) begin
      if (srst)
         wrPend <= 1'b0;
      else
         wrPend <= hsel && htrans == SAU_HTRANS_NONSEQ && hready && hwrite
                   && haddr[7:0] == SAU_ADDR_STATUS;
   end
   // Reference signed word sum, clamped
   assign addX   = {opFirst[31], opFirst} + {opSecond[31], opSecond};
   assign addSat = (addX[32] != addX[31]) ? {addX[32], {31{!addX[32]}}}
                                          : addX[31:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   bus_okay_a: assert property (hresp == SAU_HRESP_OKAY && hreadyout)
      else $error("Bus reply not OKAY or stalled");
   add_word_a: assert property (
      instValid && instCondPass && instOp == SAU_OP_ADDW
      |=> resValid && resData == $past(addSat))
      else $error("Word add result wrong");
   cond_fail_a: assert property (
      instValid && !instCondPass |=> !resValid && !instRejected)
      else $error("False condition still acted");
   valid_cause_a: assert property (
      resValid |-> $past(instValid && instCondPass))
      else $error("Result without a taken instruction");
   reject_excl_a: assert property (
      instRejected |-> !resValid && $past(instValid))
      else $error("Reject pulse out of place");
   sticky_rise_a: assert property (
      $rose(stickySat) |-> $past(wrPend && hwdata[0])
      || $past(instValid && instCondPass && instOp <= SAU_OP_SUBW))
      else $error("Flag set without cause");
   sticky_fall_a: assert property (
      $fell(stickySat) |-> $past(wrPend && !hwdata[0]))
      else $error("Flag cleared without status write");
   res_hold_a: assert property (!resValid |-> $stable(resData))
      else $error("Result changed without a write");
endmodule // sau_checker

bind sau_core sau_checker u_chk (
   .clk          (clk),
   .srst         (srst),
   .instValid    (instValid),
   .instOp       (instOp),
   .instCondPass (instCondPass),
   .opFirst      (opFirst),
   .opSecond     (opSecond),
   .resValid     (resValid),
   .resData      (resData),
   .instRejected (instRejected),
   .stickySat    (stickySat),
   .hsel         (hsel),
   .haddr        (haddr),
   .htrans       (htrans),
   .hwrite       (hwrite),
   .hwdata       (hwdata),
   .hready       (hready),
   .hreadyout    (hreadyout),
   .hresp        (hresp)
);

// >>> verification/sau_core_tb_top.sv
`timescale 1ns/100ps
module sau_core_tb_top
   import sau_pkg::*;
();
   logic        clk = 0, srst = 1, instValid = 0, instCondPass = 1;
   logic        instShiftRight = 0, instDestOmitted = 0, hsel = 0, hwrite = 0;
   logic [3:0]  instOp = 0, instDest = 4'h3, instFirstReg = 4'h5;
   logic [5:0]  instWidth = 0;
   logic [4:0]  instShiftAmt = 0;
   logic [31:0] opFirst = 0, opSecond = 0, haddr = 0, hwdata = 0, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic        hready, resValid, instRejected, stickySat, hreadyout, hresp;
   logic [31:0] resData, hrdata;
   logic [3:0]  resReg;
   int          fails = 0, nCompared = 0;
   assign hready = hreadyout;
   sau_core DUT (
      .clk             (clk),
      .srst            (srst),
      .instValid       (instValid),
      .instOp          (instOp),
      .instCondPass    (instCondPass),
      .instWidth       (instWidth),
      .instShiftRight  (instShiftRight),
      .instShiftAmt    (instShiftAmt),
      .instDest        (instDest),
      .instDestOmitted (instDestOmitted),
      .instFirstReg    (instFirstReg),
      .opFirst         (opFirst),
      .opSecond        (opSecond),
      .resValid        (resValid),
      .resData         (resData),
      .resReg          (resReg),
      .instRejected    (instRejected),
      .stickySat       (stickySat),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hready),
      .hreadyout       (hreadyout),
      .hrdata          (hrdata),
      .hresp           (hresp)
   );
   sau_rf_model rf (.clk, .resValid, .resData, .resReg);
   // Clock
   initial forever #2 clk = ~clk;
   task automatic chk(input logic [31:0] seen, exp);
      nCompared++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (fails == 0 && nCompared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One AHB-Lite single transfer
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1;
      htrans <= SAU_HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      #1;
   endtask
   // One instruction, then its result and flag
   task automatic t(input logic [3:0] op, input logic [5:0] w,
                    input logic sr, input logic [4:0] s,
                    input logic [31:0] a, b, e, input logic q, ok);
      @(posedge clk);
      instValid <= 1;
      instOp <= op;
      instWidth <= w;
      instShiftRight <= sr;
      instShiftAmt <= s;
      opFirst <= a;
      opSecond <= b;
      @(posedge clk);
      instValid <= 0;
      #1;
      chk(resValid, ok);
      chk(instRejected, !ok && instCondPass);
      if (ok)
         chk(resData, e);
      if (ok)
         chk(resReg, instDestOmitted ? instFirstReg : instDest);
      chk(stickySat, q);
   endtask
   // Watchdog
   initial begin
      #20000;
      fails++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      bus(0, SAU_ADDR_STATUS, 0); chk(rd, 0);
      bus(0, 8'h08, 0); chk(rd, 0);
      bus(1, SAU_ADDR_SATCNT, 32'h5);
      bus(0, SAU_ADDR_SATCNT, 0); chk(rd, 0);
      t(SAU_OP_SWC, 8, 0, 0, 0, 32'h200, 32'h7f, 1, 1);
      bus(0, SAU_ADDR_STATUS, 0); chk(rd, 1);
      bus(1, SAU_ADDR_STATUS, 0); chk(stickySat, 0);
      t(SAU_OP_ADDB, 0, 0, 0, 32'h7f7f7f80, 32'h01018180, 32'h7f7f0080, 0, 1);
      t(SAU_OP_SUBB, 0, 0, 0, 32'h80057f10, 32'h0107ff20, 32'h80fe7ff0, 0, 1);
      t(SAU_OP_ADDH, 0, 0, 0, 32'h7fff0001, 32'h0001ffff, 32'h7fff0000, 0, 1);
      t(SAU_OP_SUBH, 0, 0, 0, 32'h80000005, 32'h00010007, 32'h8000fffe, 0, 1);
      t(SAU_OP_SWC, 8, 0, 0, 0, 32'hffffff00, 32'hffffff80, 1, 1);
      t(SAU_OP_SWC, 32, 0, 4, 0, 32'h10000001, 32'h10, 1, 1);
      t(SAU_OP_SWC, 1, 1, 31, 0, 32'h80000000, 32'hffffffff, 1, 1);
      t(SAU_OP_UWC, 0, 0, 0, 0, 32'hfffffffb, 0, 1, 1);
      t(SAU_OP_UWC, 31, 0, 0, 0, 32'h7fffffff, 32'h7fffffff, 1, 1);
      t(SAU_OP_UWC, 4, 1, 1, 0, 32'h40, 32'hf, 1, 1);
      t(SAU_OP_SDHC, 16, 0, 0, 0, 32'h7fff8000, 32'h7fff8000, 1, 1);
      t(SAU_OP_SDHC, 9, 0, 0, 0, 32'h0100ff00, 32'h00ffff00, 1, 1);
      t(SAU_OP_UDHC, 15, 0, 0, 0, 32'h80007fff, 32'h7fff, 1, 1);
      t(SAU_OP_UDHC, 4, 0, 0, 0, 32'h0011fffe, 32'h000f0000, 1, 1);
      t(SAU_OP_ADDW, 0, 0, 0, 32'h7fffffff, 1, 32'h7fffffff, 1, 1);
      t(SAU_OP_SUBW, 0, 0, 0, 32'h80000000, 1, 32'h80000000, 1, 1);
      bus(1, SAU_ADDR_STATUS, 0); chk(stickySat, 0);
      t(SAU_OP_SWC, 0, 0, 0, 0, 32'h200, 0, 0, 0);
      t(SAU_OP_SWC, 33, 0, 0, 0, 32'h200, 0, 0, 0);
      t(SAU_OP_UWC, 32, 0, 0, 0, 32'h200, 0, 0, 0);
      t(SAU_OP_SDHC, 17, 0, 0, 0, 32'h200, 0, 0, 0);
      t(SAU_OP_UDHC, 16, 0, 0, 0, 32'h200, 0, 0, 0);
      t(SAU_OP_SWC, 8, 1, 0, 0, 32'h200, 0, 0, 0);
      t(4'ha, 8, 0, 0, 0, 32'h200, 0, 0, 0);
      @(posedge clk);
      instCondPass <= 0;
      t(SAU_OP_SWC, 8, 0, 0, 0, 32'h200, 0, 0, 0);
      @(posedge clk);
      instCondPass <= 1;
      instDestOmitted <= 1;
      bus(0, SAU_ADDR_SATCNT, 0); chk(rd, 32'h9);
      bus(1, SAU_ADDR_STATUS, 1); chk(stickySat, 1);
      t(SAU_OP_ADDW, 0, 0, 0, 5, 6, 32'hb, 1, 1);
      @(posedge clk);
      #1;
      chk(rf.regs[5], 32'hb);
      wrap_up();
   end
endmodule // sau_core_tb_top

// >>> verification/sau_rf_model.sv
`timescale 1ns/100ps
// Register file that takes the unit's result writes
module sau_rf_model
   import sau_pkg::*;
(
   input wire logic                 clk,
   input wire logic                 resValid,
   input wire logic [SAU_XLEN-1:0]  resData,
   input wire logic [SAU_REG_W-1:0] resReg
);
   logic [SAU_XLEN-1:0] regs [16];
   always_ff @(posedge clk) begin
      if (resValid)
         regs[resReg] <= resData;
   end
endmodule // sau_rf_model
